//--- shared/pfps_pkg.sv
/*
 * Shared constants for the flyback startup and fault-protection sequencer.
 * Assumes a single 20 MHz core clock; all analog levels arrive as comparator
 * flags from outside the clock domain.
 */
// Notes on behaviour
// - add a rising ramp, restarted each switching cycle, to sensed current.
// - every switch turn-on starts a 150 ns blanking interval.
// - current-limit comparator is ignored while blanking runs.
// - charge from high-voltage pin during startup; stop and switch at 17.5 V.
// - supply OV and brownout auto-restart; sense OV, heat and shutdown latch.
// - auto-restart fault stops switching; at 5.8 V clear it and recharge.
// - after auto-restart clear, switch again at 17.5 V; repeat while faulty.
// - latched fault stops switching; at 5.8 V recharge but keep fault latched.
// - latched fault at 17.5 V does not switch; charging stops, supply cycles.
// - latched fault clears only when supply decays to 2.5 V.
// - supply above 28 V raises the auto-restart overvoltage fault.
// - sense current under 160 uA in conduction over 30 ms raises brownout.
// - junction above 140 C stops output and latches protection.
// - sample auxiliary sense voltage near each diode conduction end.
// - sense sample under 1.55 V past debounce count: auto-restart fault.
// - sense under-voltage fault is masked for 45 ms after power-on.
// - sampled sense above 3.2 V beyond debounce count latches protection.
// - external shutdown pin below 1.0 V latches protection.
// - outside blanking, current limit ends the gate pulse within the cycle.
package pfps_pkg;
  localparam int unsigned CLK_PERIOD_NS        = 50;
  localparam int unsigned BLANK_NS             = 150;
  localparam int unsigned BLANK_CYC            =
    (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BROWNOUT_MS          = 30;
  localparam int unsigned BROWNOUT_CYC         =
    BROWNOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned LOW_MASK_MS          = 45;
  localparam int unsigned LOW_MASK_CYC         =
    LOW_MASK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned LOW_DEBOUNCE_COUNT   = 8;
  localparam int unsigned HIGH_DEBOUNCE_COUNT  = 8;
  localparam int unsigned DEB_W                = 4;
  localparam int unsigned LONG_W               = 22;
  localparam int unsigned RAMP_W               = 8;
  localparam int unsigned RAMP_STEP            = 1;
  localparam logic [7:0]  RAMP_RESET           = 8'h00;
  // sequencer states
  typedef enum logic [3:0] {
    PFPS_CHARGE = 4'h1,
    PFPS_RUN    = 4'h2,
    PFPS_FAULT  = 4'h4,
    PFPS_LATCH  = 4'h8
  } pfps_state_t;
endpackage : pfps_pkg

//--- logic/pfps_sync.sv
/*
 * Two-flop synchroniser bank for comparator flags and pins.
 * Assumes inputs are asynchronous to core_clk_i.
 */
module pfps_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule // pfps_sync

//--- logic/pfps_seq.sv
/*
 * Startup and fault-protection sequencer: gate blanking and current limit,
 * high-voltage startup against supply levels, auto-restart and latched
 * faults. Assumes comparator flags from the analog front end, a gate
 * request from the PWM modulator and a diode-end sample strobe.
 */
module pfps_seq #(
  parameter int unsigned BROWNOUT_CYC = pfps_pkg::BROWNOUT_CYC,
  parameter int unsigned LOW_MASK_CYC = pfps_pkg::LOW_MASK_CYC
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       pwm_req_i,
  input  wire logic                       cycle_start_i,
  input  wire logic                       peak_current_cmp_i,
  input  wire logic                       supply_on_cmp_i,
  input  wire logic                       supply_off_cmp_i,
  input  wire logic                       supply_reset_cmp_i,
  input  wire logic                       supply_ovp_cmp_i,
  input  wire logic                       sense_current_low_i,
  input  wire logic                       junction_hot_i,
  input  wire logic                       diode_end_i,
  input  wire logic                       sense_low_cmp_i,
  input  wire logic                       sense_high_cmp_i,
  input  wire logic                       shutdown_low_i,
  output logic                            gate_o,
  output logic                            hv_startup_en_o,
  output logic                            turn_on_blanking_o,
  output logic [pfps_pkg::RAMP_W-1:0]     slope_ramp_o,
  output logic                            auto_fault_o,
  output logic                            latched_fault_o,
  output logic                            overvoltage_fault_o,
  output logic                            undervoltage_fault_o
);
  localparam int unsigned NS = 13;
  logic [NS-1:0] raw;
  logic [NS-1:0] s;
  logic pwm_req, cyc_st, ilim, v_on, v_off, v_rst, v_ovp, i_low, hot;
  logic d_end, s_low, s_high, sd_low;

  // all comparator flags pass two flops before use
  assign raw = {pwm_req_i, cycle_start_i, peak_current_cmp_i,
                supply_on_cmp_i, supply_off_cmp_i, supply_reset_cmp_i,
                supply_ovp_cmp_i, sense_current_low_i, junction_hot_i,
                diode_end_i, sense_low_cmp_i, sense_high_cmp_i,
                shutdown_low_i};
  pfps_sync #(.W(NS)) u_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .async_i    (raw),
    .sync_o     (s)
  );
  assign {pwm_req, cyc_st, ilim, v_on, v_off, v_rst, v_ovp, i_low, hot,
          d_end, s_low, s_high, sd_low} = s;

  // saturating increment shared by the mask and brownout counters
  function automatic logic [pfps_pkg::LONG_W-1:0] sat_inc(
    input logic [pfps_pkg::LONG_W-1:0] v, input int unsigned lim);
    sat_inc = (v >= pfps_pkg::LONG_W'(lim)) ? v : v + 1'b1;
  endfunction

  pfps_pkg::pfps_state_t state_reg, state_next;
  logic       gate_reg, gate_next;
  logic       req_d_reg, req_d_next;
  logic [1:0] blank_reg, blank_next;
  logic       blank_out_reg, blank_out_next;
  logic [pfps_pkg::RAMP_W-1:0] ramp_reg, ramp_next;
  logic [pfps_pkg::LONG_W-1:0] bo_cnt_reg, bo_cnt_next;
  logic [pfps_pkg::LONG_W-1:0] mask_cnt_reg, mask_cnt_next;
  logic [pfps_pkg::DEB_W-1:0]  low_cnt_reg, low_cnt_next;
  logic [pfps_pkg::DEB_W-1:0]  high_cnt_reg, high_cnt_next;
  logic       s_low_smp_reg, s_low_smp_next;
  logic       s_high_smp_reg, s_high_smp_next;
  logic       smp_vld_reg, smp_vld_next;
  logic       hv_reg, hv_next;
  logic       auto_reg, auto_next;
  logic       latch_reg, latch_next;
  logic       ovf_reg, ovf_next;
  logic       uvf_reg, uvf_next;
  logic       brownout, uv_trip, ov_trip, auto_ev, latch_ev, mask_done;

  // fault detection from the current state of counters and flags
  always_comb begin
    mask_done = (mask_cnt_reg >= pfps_pkg::LONG_W'(LOW_MASK_CYC));
    brownout  = (bo_cnt_reg >= pfps_pkg::LONG_W'(BROWNOUT_CYC));
    uv_trip   = mask_done && (low_cnt_reg > pfps_pkg::DEB_W'(
                pfps_pkg::LOW_DEBOUNCE_COUNT));
    ov_trip   = high_cnt_reg > pfps_pkg::DEB_W'(
                pfps_pkg::HIGH_DEBOUNCE_COUNT);
    auto_ev   = v_ovp || brownout || uv_trip;
    latch_ev  = ov_trip || hot || sd_low;
  end

  // timing counters, sampling and debounce
  always_comb begin
    mask_cnt_next   = sat_inc(mask_cnt_reg, LOW_MASK_CYC);
    bo_cnt_next     = (gate_reg && i_low) ? sat_inc(bo_cnt_reg, BROWNOUT_CYC)
                    : (gate_reg ? '0 : bo_cnt_reg);
    s_low_smp_next  = s_low_smp_reg;
    s_high_smp_next = s_high_smp_reg;
    smp_vld_next    = 1'b0;
    low_cnt_next    = low_cnt_reg;
    high_cnt_next   = high_cnt_reg;
    if (d_end) begin
      s_low_smp_next  = s_low;
      s_high_smp_next = s_high;
      smp_vld_next    = 1'b1;
    end
    if (smp_vld_reg) begin
      low_cnt_next  = !s_low_smp_reg ? '0 :
        (&low_cnt_reg ? low_cnt_reg : low_cnt_reg + 1'b1);
      high_cnt_next = !s_high_smp_reg ? '0 :
        (&high_cnt_reg ? high_cnt_reg : high_cnt_reg + 1'b1);
    end
    if (state_reg != pfps_pkg::PFPS_RUN) begin
      low_cnt_next  = '0;
      high_cnt_next = '0;
      bo_cnt_next   = '0;
    end
  end

  // supply sequencing state machine
  always_comb begin
    state_next = state_reg;
    hv_next    = hv_reg;
    auto_next  = auto_reg;
    latch_next = latch_reg;
    ovf_next   = ovf_reg;
    uvf_next   = uvf_reg;
    unique case (state_reg)
      pfps_pkg::PFPS_CHARGE: begin
        hv_next = 1'b1;
        if (v_on) begin
          hv_next    = 1'b0;
          state_next = pfps_pkg::PFPS_RUN;
        end
      end
      pfps_pkg::PFPS_RUN: begin
        if (latch_ev) begin
          latch_next = 1'b1;
          ovf_next   = ov_trip;
          state_next = pfps_pkg::PFPS_LATCH;
        end else if (auto_ev) begin
          auto_next  = 1'b1;
          uvf_next   = uv_trip;
          state_next = pfps_pkg::PFPS_FAULT;
        end else if (v_off) begin
          hv_next    = 1'b1;
          state_next = pfps_pkg::PFPS_CHARGE;
        end
      end
      pfps_pkg::PFPS_FAULT: begin
        if (v_off) begin
          auto_next  = 1'b0;
          uvf_next   = 1'b0;
          hv_next    = 1'b1;
          state_next = pfps_pkg::PFPS_CHARGE;
        end
      end
      pfps_pkg::PFPS_LATCH: begin
        if (v_rst) begin
          latch_next = 1'b0;
          ovf_next   = 1'b0;
          hv_next    = 1'b1;
          state_next = pfps_pkg::PFPS_CHARGE;
        end else if (v_off) begin
          hv_next = 1'b1;
        end else if (v_on) begin
          hv_next = 1'b0;
        end
      end
      default: begin
        state_next = pfps_pkg::PFPS_CHARGE;
        hv_next    = 1'b1;
      end
    endcase
  end

  // gate drive, blanking and slope ramp
  always_comb begin
    req_d_next     = pwm_req;
    gate_next      = gate_reg;
    blank_next     = blank_reg;
    blank_out_next = 1'b0;
    ramp_next      = cyc_st ? pfps_pkg::RAMP_RESET
                   : ramp_reg + pfps_pkg::RAMP_W'(pfps_pkg::RAMP_STEP);
    if (pwm_req && !req_d_reg && state_reg == pfps_pkg::PFPS_RUN
        && !latch_ev && !auto_ev) begin
      gate_next  = 1'b1;
      blank_next = 2'(pfps_pkg::BLANK_CYC);
    end else if (gate_reg) begin
      if (blank_reg != 2'h0) begin
        blank_next = blank_reg - 2'h1;
      end
      if (!pwm_req || (ilim && blank_reg == 2'h0)) begin
        gate_next  = 1'b0;
      end
    end
    if (gate_next && blank_next != 2'h0) begin
      blank_out_next = 1'b1;
    end
    if (state_reg != pfps_pkg::PFPS_RUN || latch_ev || auto_ev) begin
      gate_next = 1'b0;
    end
  end

  // register every group
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg      <= pfps_pkg::PFPS_CHARGE;
      gate_reg       <= 1'b0;
      req_d_reg      <= 1'b0;
      blank_reg      <= 2'h0;
      blank_out_reg  <= 1'b0;
      ramp_reg       <= pfps_pkg::RAMP_RESET;
      bo_cnt_reg     <= '0;
      mask_cnt_reg   <= '0;
      low_cnt_reg    <= '0;
      high_cnt_reg   <= '0;
      s_low_smp_reg  <= 1'b0;
      s_high_smp_reg <= 1'b0;
      smp_vld_reg    <= 1'b0;
      hv_reg         <= 1'b1;
      auto_reg       <= 1'b0;
      latch_reg      <= 1'b0;
      ovf_reg        <= 1'b0;
      uvf_reg        <= 1'b0;
    end else begin
      state_reg      <= state_next;
      gate_reg       <= gate_next;
      req_d_reg      <= req_d_next;
      blank_reg      <= blank_next;
      blank_out_reg  <= blank_out_next;
      ramp_reg       <= ramp_next;
      bo_cnt_reg     <= bo_cnt_next;
      mask_cnt_reg   <= mask_cnt_next;
      low_cnt_reg    <= low_cnt_next;
      high_cnt_reg   <= high_cnt_next;
      s_low_smp_reg  <= s_low_smp_next;
      s_high_smp_reg <= s_high_smp_next;
      smp_vld_reg    <= smp_vld_next;
      hv_reg         <= hv_next;
      auto_reg       <= auto_next;
      latch_reg      <= latch_next;
      ovf_reg        <= ovf_next;
      uvf_reg        <= uvf_next;
    end
  end

  assign gate_o               = gate_reg;
  assign hv_startup_en_o      = hv_reg;
  assign turn_on_blanking_o   = blank_out_reg;
  assign slope_ramp_o         = ramp_reg;
  assign auto_fault_o         = auto_reg;
  assign latched_fault_o      = latch_reg;
  assign overvoltage_fault_o  = ovf_reg;
  assign undervoltage_fault_o = uvf_reg;

  // checks beside the logic, all on the core clock
  default clocking chk_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  blank_len_a: assert property ($rose(gate_reg) |->
    blank_reg == 2'(pfps_pkg::BLANK_CYC))
    else $error("blanking not loaded at turn-on");
  blank_ilim_a: assert property (gate_reg && blank_reg != 2'h0 &&
    pwm_req && state_reg == pfps_pkg::PFPS_RUN && !latch_ev && !auto_ev
    |=> gate_reg)
    else $error("gate ended during blanking");
  ilim_cut_a: assert property (gate_reg && ilim &&
    blank_reg == 2'h0 |=> !gate_reg)
    else $error("current limit did not end pulse");
  hv_on_a: assert property (state_reg == pfps_pkg::PFPS_CHARGE &&
    v_on |=> !hv_reg && state_reg == pfps_pkg::PFPS_RUN)
    else $error("startup did not hand over");
  auto_clr_a: assert property (state_reg == pfps_pkg::PFPS_FAULT &&
    v_off |=> !auto_reg && hv_reg)
    else $error("auto fault not cleared");
  latch_keep_a: assert property (latch_reg && !v_rst |=>
    latch_reg && !gate_reg)
    else $error("latched fault lost");
  latch_noon_a: assert property (state_reg == pfps_pkg::PFPS_LATCH &&
    v_on && !v_off && !v_rst |=> !hv_reg ##1 !gate_reg)
    else $error("latched fault resumed");
  ovp_auto_a: assert property (state_reg == pfps_pkg::PFPS_RUN &&
    v_ovp && !latch_ev |=> auto_reg)
    else $error("supply overvoltage missed");
  hot_latch_a: assert property (state_reg == pfps_pkg::PFPS_RUN &&
    hot |=> latch_reg)
    else $error("over-temperature missed");
  sd_latch_a: assert property (state_reg == pfps_pkg::PFPS_RUN &&
    sd_low |=> latch_reg)
    else $error("shutdown pin missed");
  uv_mask_a: assert property (
    mask_cnt_reg < pfps_pkg::LONG_W'(LOW_MASK_CYC) |=> !uvf_reg)
    else $error("undervoltage during mask");
  deb_clr_a: assert property (smp_vld_reg && !s_high_smp_reg |=>
    high_cnt_reg == '0)
    else $error("debounce not restarted");
  run_c: cover property ($rose(gate_reg));
  auto_c: cover property ($rose(auto_reg));
  latch_c: cover property ($fell(latch_reg));
endmodule // pfps_seq

//--- sim/pfps_analog_model.sv
/*
 * Analog front end model: supply level comparators and switch current trip.
 * Assumes the bench sets the supply level in millivolts and the trip point
 * in gate-on cycles, and that gate_i comes from the sequencer.
 */
module pfps_analog_model (
  input  wire logic               core_clk_i,
  input  wire logic signed [31:0] supply_mv_i,
  input  wire logic signed [31:0] peak_lim_i,
  input  wire logic               gate_i,
  output logic                    supply_on_o,
  output logic                    supply_off_o,
  output logic                    supply_reset_o,
  output logic                    supply_ovp_o,
  output logic                    peak_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int on_cnt;
  // supply crossings reach the logic as single-bit flags
  assign supply_on_o    = supply_mv_i >= 17500;
  assign supply_off_o   = supply_mv_i <= 5800;
  assign supply_reset_o = supply_mv_i <= 2500;
  assign supply_ovp_o   = supply_mv_i > 28000;
  // switch current grows while the gate is on and trips at the limit
  always @(posedge core_clk_i) begin
    on_cnt <= gate_i ? on_cnt + 1 : 0;
  end
  assign peak_o = gate_i && on_cnt >= peak_lim_i;
endmodule // pfps_analog_model

//--- sim/pfps_seq_tb.sv
/*
 * Self-checking bench for the startup and fault-protection sequencer.
 * Assumes a 20 MHz clock and shortened brownout and mask counts.
 */
module pfps_seq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       pwm_req = 1'b0, cyc_st = 1'b0, diode_end = 1'b0;
  logic       s_low = 1'b0, cur_low = 1'b0;
  logic [2:0] src = 3'h0;
  int         supply_mv = 12000, peak_lim = 1000;
  int         n_errors = 0, n_compared = 0;
  logic       gate_o, hv_o, blank_o, auto_o, latch_o, ov_o, uv_o, peak;
  logic       s_on, s_off, s_rst, s_ovp;
  logic [7:0] ramp_o;
  // clock generator
  always #25 core_clk_i = ~core_clk_i;
  pfps_analog_model afe (.core_clk_i(core_clk_i), .supply_mv_i(supply_mv),
    .peak_lim_i(peak_lim), .gate_i(gate_o), .supply_on_o(s_on),
    .supply_off_o(s_off), .supply_reset_o(s_rst), .supply_ovp_o(s_ovp),
    .peak_o(peak));
  pfps_seq #(.BROWNOUT_CYC(50), .LOW_MASK_CYC(80)) dut (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .pwm_req_i(pwm_req),
    .cycle_start_i(cyc_st), .peak_current_cmp_i(peak),
    .supply_on_cmp_i(s_on), .supply_off_cmp_i(s_off),
    .supply_reset_cmp_i(s_rst), .supply_ovp_cmp_i(s_ovp),
    .sense_current_low_i(cur_low), .junction_hot_i(src[0]),
    .diode_end_i(diode_end), .sense_low_cmp_i(s_low),
    .sense_high_cmp_i(src[2]), .shutdown_low_i(src[1]), .gate_o(gate_o),
    .hv_startup_en_o(hv_o), .turn_on_blanking_o(blank_o),
    .slope_ramp_o(ramp_o), .auto_fault_o(auto_o), .latched_fault_o(latch_o),
    .overvoltage_fault_o(ov_o), .undervoltage_fault_o(uv_o));
  // advance n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one gate request held until the gate rises or 10 cycles pass, then 20 cycles more; counts gate and blanking cycles
  task automatic pulse(input int lim, output int hi, output int bl);
    int i;
    peak_lim = lim;
    pwm_req = 1'b1;
    hi = 0;
    bl = 0;
    for (i = 0; i < 10 && gate_o !== 1'b1; i++) tick(1);
    for (i = 0; i < 20; i++) begin
      hi += int'(gate_o === 1'b1);
      bl += int'(blank_o === 1'b1);
      tick(1);
    end
    pwm_req = 1'b0;
    tick(2);
  endtask
  // drain the supply to the off level and charge it back to turn-on
  task automatic recover;
    supply_mv = 5000;
    tick(4);
    supply_mv = 18000;
    tick(4);
  endtask
  task automatic report_and_stop;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    repeat (6000) @(posedge core_clk_i);
    n_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    int         hi, bl, k;
    logic [7:0] r0;
    tick(16);
    check(gate_o, 1'b0);
    check(hv_o, 1'b1);
    check(ramp_o, 8'h00);
    check({auto_o, latch_o}, 2'h0);
    arst_n_i = 1'b1;
    supply_mv = 18000;
    tick(4);
    check(hv_o, 1'b0);
    diode_end = 1'b1;
    s_low = 1'b1;
    tick(12);
    check(uv_o, 1'b0);
    s_low = 1'b0;
    cyc_st = 1'b1;
    tick(4);
    check(ramp_o, 8'h00);
    cyc_st = 1'b0;
    tick(3);
    r0 = ramp_o;
    tick(4);
    check(8'(ramp_o - r0), 8'h04);
    pulse(0, hi, bl);
    check(bl, pfps_pkg::BLANK_CYC);
    check(hi, pfps_pkg::BLANK_CYC + 1);
    pulse(1000, hi, bl);
    check(hi, 20);
    tick(80);
    s_low = 1'b1;
    tick(6);
    check(uv_o, 1'b0);
    s_low = 1'b0;
    tick(2);
    s_low = 1'b1;
    tick(8);
    check(uv_o, 1'b0);
    tick(6);
    check({uv_o, auto_o, gate_o}, 3'h6);
    s_low = 1'b0;
    diode_end = 1'b0;
    supply_mv = 5000;
    tick(4);
    check({auto_o, hv_o}, 2'h1);
    supply_mv = 18000;
    tick(4);
    check(hv_o, 1'b0);
    pulse(1000, hi, bl);
    check(hi, 20);
    supply_mv = 29000;
    tick(4);
    check({auto_o, gate_o}, 2'h2);
    recover();
    cur_low = 1'b1;
    peak_lim = 100000;
    pwm_req = 1'b1;
    tick(70);
    check({auto_o, gate_o}, 2'h2);
    pwm_req = 1'b0;
    cur_low = 1'b0;
    recover();
    for (k = 0; k < 3; k++) begin
      src = 3'h1 << k;
      diode_end = 1'b1;
      tick(14);
      check({latch_o, gate_o}, 2'h2);
      check(ov_o, 1'(k == 2));
      src = 3'h0;
      diode_end = 1'b0;
      supply_mv = 5000;
      tick(4);
      check({latch_o, hv_o}, 2'h3);
      supply_mv = 18000;
      tick(4);
      check({latch_o, hv_o}, 2'h2);
      pulse(1000, hi, bl);
      check(hi, 0);
      supply_mv = 2000;
      tick(4);
      check(latch_o, 1'b0);
      recover();
    end
    supply_mv = 5000;
    tick(4);
    check({hv_o, gate_o}, 2'h2);
    report_and_stop();
  end
endmodule // pfps_seq_tb
